//--- design/sample_fifo.sv
// Sample FIFO between the serial link domain result and the system-side sample outputs.
// Assumes one clock; crossing handled by the main module.
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_r;
  logic [AW:0] rdPtr_r;
  logic full;
  logic empty;
  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
    end else if (inValid && !full) begin
      wrPtr_r <= wrPtr_r + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdPtr_r <= '0;
    end else if (outReady && !empty) begin
      rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- design/sar_conversion_port.sv
// Control logic of a 12-bit successive approximation converter with serial read-out.
// Assumes the comparator answers dacCode at once; the serial clock has its own port.
`timescale 1ns/10ps
`default_nettype none
`include "sar_port_params.svh"
module sar_conversion_port
  import sar_port_pkg::*;
#(
  parameter int RESULT_BITS = `RESULT_BITS,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic power_down_n,
  input wire logic compareIn,
  output logic compareReady,
  output logic [RESULT_BITS-1:0] dacCode,
  output logic dataOut,
  output logic dataOutEn,
  output logic trackHoldN,
  output logic referenceEn,
  output logic sampleValid,
  output logic [RESULT_BITS-1:0] sampleData,
  input wire logic sampleReady,
  output logic acqViolation
);
  // ****************************************************************
  // Link domain: serial clock side
  // ****************************************************************
  // Link logic apart from the done toggle and result word sits in reset unless a frame is open in normal mode.
  logic linkRstn;
  link_state_type linkState_r;
  link_state_type linkState_nxt;
  logic [`EDGE_CNT_W-1:0] edgeCnt_r;
  logic [RESULT_BITS-1:0] sar_r;
  logic [RESULT_BITS-1:0] sarTrial;
  logic outBit_r;
  logic doneTog_r;
  logic [RESULT_BITS-1:0] result_r;
  int bitIdx;

  // Chip select high clears the link logic asynchronously, apart from the done toggle and result word,
  // so nothing depends on an edge that arrives after the frame ends.
  assign linkRstn = rstn & ~chipSelectN & power_down_n;

  // Comparator answers the trial code within one edge; flops there would skew every decision.

  assign bitIdx = RESULT_BITS - 1 - (int'(edgeCnt_r) - `FIRST_MSB_EDGE + 1);

  always_comb begin
    linkState_nxt = linkState_r;
    unique case (linkState_r)
      LINK_IDLE: begin
        linkState_nxt = LINK_CONVERT;
      end
      LINK_CONVERT: begin
        if (edgeCnt_r == `EDGE_CNT_W'(`LAST_BIT_EDGE - 1)) begin
          linkState_nxt = LINK_TRAIL;
        end
      end
      LINK_TRAIL: begin
        linkState_nxt = LINK_TRAIL;
      end
    endcase
  end

  always_ff @(posedge serialClk or negedge linkRstn) begin
    if (!linkRstn) begin
      linkState_r <= LINK_IDLE;
    end else begin
      linkState_r <= linkState_nxt;
    end
  end

  // Edge counter stops at the last bit so extra clocks leave it alone.
  always_ff @(posedge serialClk or negedge linkRstn) begin
    if (!linkRstn) begin
      edgeCnt_r <= '0;
    end else if (linkState_r != LINK_TRAIL) begin
      edgeCnt_r <= edgeCnt_r + 1'b1;
    end
  end

  // Trial code: bits decided so far plus the trial bit under test.
  always_comb begin
    sarTrial = sar_r;
    if (bitIdx >= 0 && bitIdx < RESULT_BITS) begin
      sarTrial[bitIdx] = 1'b1;
    end
  end

  // Each edge from the third to the fourteenth keeps or drops one trial bit, MSB first.
  always_ff @(posedge serialClk or negedge linkRstn) begin
    if (!linkRstn) begin
      sar_r <= '0;
    end else if (linkState_r == LINK_CONVERT && edgeCnt_r >= `EDGE_CNT_W'(`FIRST_MSB_EDGE - 1)
                 && bitIdx >= 0) begin
      sar_r <= compareIn ? sarTrial : sar_r;
    end
  end

  // Output bit: zeros for the first two edges, then each decided bit, then zeros.
  always_ff @(posedge serialClk or negedge linkRstn) begin
    if (!linkRstn) begin
      outBit_r <= 1'b0;
    end else if (linkState_r == LINK_CONVERT && edgeCnt_r >= `EDGE_CNT_W'(`FIRST_MSB_EDGE - 1)
                 && bitIdx >= 0) begin
      outBit_r <= compareIn;
    end else begin
      outBit_r <= 1'b0;
    end
  end

  // Completed result toggles an event flag across to clk.
  always_ff @(posedge serialClk or negedge rstn) begin
    if (!rstn) begin
      doneTog_r <= 1'b0;
      result_r <= '0;
    end else if (linkState_r == LINK_CONVERT && linkState_nxt == LINK_TRAIL && chipSelectN == 1'b0) begin
      doneTog_r <= ~doneTog_r;
      result_r <= compareIn ? sarTrial : sar_r;
    end
  end

  assign dataOut = outBit_r;
  assign dataOutEn = ~chipSelectN & power_down_n;
  assign dacCode = sarTrial;

  // ****************************************************************
  // System domain: track/hold, reference and result hand-off
  // ****************************************************************
  logic pdn1_r;
  logic pdn2_r;
  logic cs1_r;
  logic cs2_r;
  logic cs3_r;
  logic done1_r;
  logic done2_r;
  logic done3_r;
  logic hold_r;
  logic converting_r;
  logic [15:0] acqCnt_r;
  logic acqViol_r;
  logic fifoInReady;
  logic pushEvt;
  logic csFall;
  logic csRise;
  localparam logic [15:0] ACQ_CYC = 16'(`ACQ_MIN_CYC);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pdn1_r <= 1'b0;
      pdn2_r <= 1'b0;
      cs1_r <= 1'b1;
      cs2_r <= 1'b1;
      cs3_r <= 1'b1;
      done1_r <= 1'b0;
      done2_r <= 1'b0;
      done3_r <= 1'b0;
    end else begin
      pdn1_r <= power_down_n;
      pdn2_r <= pdn1_r;
      cs1_r <= chipSelectN;
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      done1_r <= doneTog_r;
      done2_r <= done1_r;
      done3_r <= done2_r;
    end
  end

  assign csFall = cs3_r & ~cs2_r;
  assign csRise = ~cs3_r & cs2_r;
  assign pushEvt = done3_r ^ done2_r;

  // Reference follows the mode; off means no conversion can succeed.
  assign referenceEn = pdn2_r;
  // The hold switch is driven straight from the pin so the sample is taken at the edge.
  assign trackHoldN = ~(~chipSelectN & power_down_n & ~converting_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= 1'b0;
      converting_r <= 1'b0;
    end else if (!pdn2_r) begin
      hold_r <= 1'b0;
      converting_r <= 1'b0;
    end else if (pushEvt || csRise) begin
      hold_r <= 1'b0;
      converting_r <= pushEvt & ~cs2_r;
    end else if (csFall) begin
      hold_r <= 1'b1;
      converting_r <= 1'b0;
    end
  end

  // Tracks time since the hold was released; early starts are flagged.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acqCnt_r <= ACQ_CYC;
      acqViol_r <= 1'b0;
    end else begin
      if (hold_r) begin
        acqCnt_r <= '0;
      end else if (acqCnt_r != ACQ_CYC) begin
        acqCnt_r <= acqCnt_r + 16'h0001;
      end
      if (csFall && pdn2_r) begin
        acqViol_r <= (acqCnt_r != ACQ_CYC);
      end
    end
  end
  assign acqViolation = acqViol_r;
  assign compareReady = hold_r;

  // Result word crosses via the toggle; a full FIFO drops the newest sample.
  sample_fifo #(
    .WIDTH(RESULT_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(pushEvt),
    .inReady(fifoInReady),
    .inData(result_r),
    .outValid(sampleValid),
    .outReady(sampleReady),
    .outData(sampleData)
  );
endmodule
`default_nettype wire

//--- design/sar_port_params.svh
// Timing and format constants for the serial conversion port.
// Assumes inclusion by bare name from the design files.
`ifndef SAR_PORT_PARAMS_SVH
`define SAR_PORT_PARAMS_SVH
`define RESULT_BITS 12
`define LEAD_ZEROS 3
`define FIRST_MSB_EDGE 3
`define LAST_BIT_EDGE 15
`define EDGE_CNT_W 5
`define FIFO_DEPTH 16
`define CONV_CLK_MHZ 100
`define ACQ_MIN_NS 468
`define ACQ_MIN_CYC ((`ACQ_MIN_NS * `CONV_CLK_MHZ + 999) / 1000)
`endif

//--- design/sar_port_pkg.sv
// Types shared by the serial conversion port.
// Assumes the params header sits alongside.
package sar_port_pkg;
  typedef enum logic [1:0] {LINK_IDLE, LINK_CONVERT, LINK_TRAIL} link_state_type;
endpackage

//--- dv/host_master.sv
// Host serial master: chip select and a gated serial clock.
// Assumes one caller of frame at a time.
`timescale 1ns/10ps
`default_nettype none
module host_master (
  output logic serialClk,
  output logic chipSelectN,
  input wire logic dataOut,
  input wire logic dataOutEn
);
  // *****
  // Frame
  // *****
  logic lineBit = 1'b0;
  initial begin
    serialClk = 1'b0;
    chipSelectN = 1'b1;
  end
  // Clock stands still between frames
  task automatic frame(input int edges, input int gapNs, output logic [15:0] word);
    word = 16'h0000;
    #(gapNs);
    chipSelectN = 1'b0;
    #43;
    repeat (edges) begin
      serialClk = 1'b1;
      #80;
      serialClk = 1'b0;
      // No pull on the line: released means inverse of last level
      lineBit = dataOutEn ? dataOut : ~lineBit;
      word = {word[14:0], lineBit};
      #80;
    end
    chipSelectN = 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/sar_port_props.sv
// Checker for the serial conversion port pins.
// Assumes binding onto sar_conversion_port.
`timescale 1ns/10ps
`default_nettype none
module sar_port_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic serialClk,
  input wire logic chipSelectN,
  input wire logic power_down_n,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic trackHoldN,
  input wire logic referenceEn,
  input wire logic compareReady
);
  // ****************
  // Frame edge count
  // ****************
  logic [4:0] edgeCnt_r;
  // Saturates so long trailing runs stay quiet
  always_ff @(posedge serialClk or negedge rstn or posedge chipSelectN) begin
    if (!rstn || chipSelectN) edgeCnt_r <= 5'h00;
    else if (edgeCnt_r != 5'h1f) edgeCnt_r <= edgeCnt_r + 5'h01;
  end
  sequence frameStart;
    $fell(chipSelectN) && power_down_n;
  endsequence
  AST_OE: assert property (@(posedge clk) disable iff (!rstn)
    dataOutEn == (!chipSelectN && power_down_n)) else $error("enable");
  AST_REF_OFF: assert property (@(posedge clk) disable iff (!rstn)
    $fell(power_down_n) |-> ##[1:2] !referenceEn) else $error("reference");
  AST_TRACK: assert property (@(posedge clk) disable iff (!rstn)
    chipSelectN |-> trackHoldN) else $error("track");
  AST_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    frameStart |-> !trackHoldN) else $error("hold");
  AST_HOLD_FLAG: assert property (@(posedge clk) disable iff (!rstn)
    frameStart |-> ##[2:3] compareReady) else $error("hold flag");
  AST_START_LOW: assert property (@(posedge clk) disable iff (!rstn)
    frameStart |-> !dataOut) else $error("start level");
  AST_SCLK_ONLY: assert property (@(posedge clk) disable iff (!rstn)
    $changed(dataOut) |-> $rose(serialClk) || $rose(chipSelectN)) else $error("change");
  AST_LEAD: assert property (@(negedge serialClk) disable iff (!rstn)
    !chipSelectN && edgeCnt_r <= 5'h02 |-> !dataOut) else $error("lead");
  AST_TRAIL: assert property (@(negedge serialClk) disable iff (!rstn)
    !chipSelectN && edgeCnt_r >= 5'h0f |-> !dataOut) else $error("trail");
endmodule
bind sar_conversion_port sar_port_props i_props (.clk(clk), .rstn(rstn),
  .serialClk(serialClk), .chipSelectN(chipSelectN), .power_down_n(power_down_n),
  .dataOut(dataOut), .dataOutEn(dataOutEn), .trackHoldN(trackHoldN),
  .referenceEn(referenceEn), .compareReady(compareReady));
`default_nettype wire

//--- dv/tb.sv
// Bench: host model runs frames, a queue scores the samples.
// Assumes host_master and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
  // *****
  // Bench
  // *****
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic power_down_n = 1'b1;
  logic sampleReady = 1'b0;
  logic [11:0] target = 12'h000;
  logic [15:0] word;
  logic [11:0] expQ[$];
  wire logic serialClk, chipSelectN, dataOut, dataOutEn, sampleValid, referenceEn, acqViolation;
  wire logic [11:0] dacCode, sampleData;
  int drain = 0;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  // Comparator keeps a trial bit while the code is not above the input
  wire logic compareIn = (dacCode <= target);
  sar_conversion_port #(.RESULT_BITS(12), .FIFO_DEPTH(16)) i_dut (.clk(clk), .rstn(rstn),
    .serialClk(serialClk), .chipSelectN(chipSelectN), .power_down_n(power_down_n),
    .compareIn(compareIn), .compareReady(), .dacCode(dacCode), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .trackHoldN(), .referenceEn(referenceEn), .sampleValid(sampleValid),
    .sampleData(sampleData), .sampleReady(sampleReady), .acqViolation(acqViolation));
  host_master i_host (.serialClk(serialClk), .chipSelectN(chipSelectN), .dataOut(dataOut),
    .dataOutEn(dataOutEn));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic convert(input bit keep);
    if (keep) expQ.push_back(target);
    i_host.frame(16, 800, word);
    check("serial", word, {2'b00, target, 2'b00});
  endtask
  always @(negedge clk) sampleReady <= (drain == 2) || (drain == 1 && $urandom_range(1));
  always @(posedge clk) begin
    if (rstn && sampleValid === 1'b1 && sampleReady) begin
      if (expQ.size() == 0) check("extra", 16'h0001, 16'h0000);
      else check("sample", 16'(sampleData), 16'(expQ.pop_front()));
    end
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("timeout");
      summarize();
    end
  end
  initial begin
    void'($urandom(85));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    drain = 1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      target = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
      convert(1'b1);
    end
    $display("random done");
    i_host.frame(6, 800, word);
    convert(1'b1);
    i_host.frame(4, 100, word);
    repeat (5) @(negedge clk);
    check("acq set", 16'(acqViolation), 16'h0001);
    convert(1'b1);
    check("acq clear", 16'(acqViolation), 16'h0000);
    $display("abort done");
    power_down_n = 1'b0;
    repeat (4) @(negedge clk);
    check("ref off", 16'(referenceEn), 16'h0000);
    i_host.frame(16, 800, word);
    @(negedge clk);
    power_down_n = 1'b1;
    repeat (4) @(negedge clk);
    check("ref on", 16'(referenceEn), 16'h0001);
    convert(1'b1);
    $display("shutdown done");
    drain = 2;
    repeat (10) @(negedge clk);
    drain = 0;
    // Overflow drops newest, so only the first sixteen come back
    for (int i = 0; i < 18; i++) begin
      @(negedge clk);
      target = 12'($urandom);
      convert(i < 16);
    end
    drain = 2;
    repeat (50) @(negedge clk);
    check("left", 16'(expQ.size()), 16'h0000);
    check("empty", 16'(sampleValid), 16'h0000);
    $display("fifo done");
    summarize();
  end
endmodule
`default_nettype wire
